// ==== include/vex_pkg.sv ====
package vex_pkg;

    // register byte offsets on the APB bus
    localparam logic [7:0] VEX_OFF_CTRL    = 8'h00;
    localparam logic [7:0] VEX_OFF_STATUS  = 8'h04;
    localparam logic [7:0] VEX_OFF_CMD_LO  = 8'h08;
    localparam logic [7:0] VEX_OFF_CMD_HI  = 8'h0c;
    localparam logic [7:0] VEX_OFF_D1_LO   = 8'h10;
    localparam logic [7:0] VEX_OFF_D1_HI   = 8'h14;
    localparam logic [7:0] VEX_OFF_D2_LO   = 8'h18;
    localparam logic [7:0] VEX_OFF_D2_HI   = 8'h1c;

    // field positions
    localparam int VEX_CTRL_EN_BIT    = 0;
    localparam int VEX_STAT_PEND_BIT  = 0;
    localparam int VEX_STAT_KIND_LSB  = 1;
    localparam int VEX_RW_BIT         = 32;

    // values after reset
    localparam logic        VEX_RST_EN   = 1'b1;
    localparam logic [31:0] VEX_RST_CMD  = 32'h0000_0000;

    // failure-cause codes
    localparam logic [31:0] VEX_CAUSE_BAD_TYPE    = 32'h0000_0000;
    localparam logic [31:0] VEX_CAUSE_NOT_SCHED   = 32'h0000_0001;
    localparam logic [31:0] VEX_CAUSE_BAD_TARGET  = 32'h0000_0002;
    localparam logic [31:0] VEX_CAUSE_BAD_BACKING = 32'h0000_0003;

    // target limits and the end-of-interrupt register offset
    localparam logic [7:0]  VEX_MAX_CLUSTER  = 8'h40;
    localparam logic [9:0]  VEX_MAX_PHYSICAL = 10'h200;
    localparam logic [11:0] VEX_EOI_OFFSET   = 12'h0b0;

    // exit codes on the exit port (values are arbitrary)
    typedef enum logic [1:0] {
        VEX_EXIT_NONE                      = 2'h0,
        VEX_EXIT_IPI_UNDELIVERED           = 2'h1,
        VEX_EXIT_UNACCELERATED_ACCESS      = 2'h2
    } vex_exit_code_t;

    // delivery status from the interrupt-routing logic
    typedef struct packed {
        logic       valid;       // one-cycle pulse: a delivery attempt ended
        logic       level_trig;
        logic       dest_unsup;
        logic       dest_logical;
        logic       dest_shorthand;
        logic       absent;
        logic [7:0] cluster;
        logic [9:0] phys_target;
        logic       bad_backing;
        logic       not_sched;
        logic [7:0] phys_index;
        logic [7:0] log_index;
    } vex_ipi_status_t;

    // guest access to a register that hardware does not accelerate
    typedef struct packed {
        logic       valid;        // one-cycle pulse
        logic       write;
        logic [11:0] offset;
        logic       eoi_level;    // eoi attempted over a level interrupt
        logic [7:0] top_vector;   // highest in-service vector
    } vex_access_t;

    typedef struct packed {
        vex_exit_code_t code;
        logic [63:0]    first;
        logic [63:0]    second;
    } vex_exit_t;

endpackage : vex_pkg

// ==== verilog/vex_encoder.sv ====
// Behaviour
// [RL1] undelivered ipi raises exit, fills both words
// [RL2] intr_cmd_high goes to first word 63:32
// [RL3] intr_cmd_low goes to first word 31:0
// [RL4] cause code in second 63:32, 31:8 reserved
// [RL5] index in 7:0 only for codes 1-3
// [RL6] level trigger or bad dest gives code 0
// [RL7] unscheduled target gives code 1 with index
// [RL8] invalid target gives code 2 with index
// [RL9] bad backing pointer gives code 3
// [RL10] code 3 index chosen by delivery mode
// [RL11] codes above 3 never produced
// [RL12] unaccelerated access raises exit, fills both words
// [RL13] level-triggered eoi also raises that exit
// [RL14] bit 32 flags write, 63:33 reserved
// [RL15] offset 11:4 into bits 11:4, rest reserved
// [RL16] eoi write puts top vector in 7:0
// [RL17] reserved bits driven as zero
//
// Implementation choices: the APB interface to the registers and the register offsets.
module vex_encoder
    import vex_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            sys_rst,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic                 pready,
    output logic [31:0]          prdata,
    output logic                 pslverr,
    input  wire vex_ipi_status_t ipi_status,
    input  wire vex_access_t     access,
    output logic                 exit_valid,
    output vex_exit_t            exit_info
);

    logic        ctrl_en;
    logic        pending;
    logic [31:0] intr_cmd_low;
    logic [31:0] intr_cmd_high;
    logic        ipi_fail;
    logic        ipi_take;
    logic        acc_take;
    logic [31:0] cause;
    logic [7:0]  index;
    logic        apb_write;
    vex_exit_t   next_exit;

    function automatic logic is_bad_target(input vex_ipi_status_t s);
        return (s.dest_logical && s.cluster > VEX_MAX_CLUSTER) ||
               (!s.dest_logical && s.phys_target > VEX_MAX_PHYSICAL) ||
               s.absent;
    endfunction : is_bad_target

    function automatic logic [7:0] dest_index(input vex_ipi_status_t s);
        return s.dest_logical ? s.log_index : s.phys_index;
    endfunction : dest_index

    // cause priority: type first, then target, backing page, scheduling;
    // a bad type stops routing so later checks mean nothing
    always_comb begin
        ipi_fail = ipi_status.level_trig || ipi_status.dest_unsup ||
                   is_bad_target(ipi_status) || ipi_status.bad_backing ||
                   ipi_status.not_sched;
        cause = VEX_CAUSE_NOT_SCHED;
        index = dest_index(ipi_status);                              // RL7
        if (ipi_status.level_trig || ipi_status.dest_unsup) begin
            cause = VEX_CAUSE_BAD_TYPE;                              // RL6
            index = 8'h00;                                           // RL5
        end else if (is_bad_target(ipi_status)) begin
            cause = VEX_CAUSE_BAD_TARGET;                            // RL8
            index = dest_index(ipi_status);
        end else if (ipi_status.bad_backing) begin
            cause = VEX_CAUSE_BAD_BACKING;                           // RL9
            index = ipi_status.dest_shorthand ? ipi_status.phys_index
                                              : dest_index(ipi_status); // RL10
        end
    end

    // an ipi exit takes precedence; a same-cycle access is dropped
    // because the core retries it after the hypervisor resumes
    assign ipi_take = ctrl_en && ipi_status.valid && ipi_fail;       // RL1
    assign acc_take = ctrl_en && !ipi_take &&
                      (access.valid || access.eoi_level);            // RL12 RL13

    always_comb begin
        next_exit = '0;                                              // RL17
        if (ipi_take) begin
            next_exit.code          = VEX_EXIT_IPI_UNDELIVERED;
            next_exit.first[63:32]  = intr_cmd_high;                 // RL2
            next_exit.first[31:0]   = intr_cmd_low;                  // RL3
            next_exit.second[63:32] = cause;                         // RL4 RL11
            next_exit.second[7:0]   = index;                         // RL5
        end else if (acc_take) begin
            next_exit.code = VEX_EXIT_UNACCELERATED_ACCESS;
            if (access.eoi_level) begin
                next_exit.first[VEX_RW_BIT] = 1'b1;                  // RL13
                next_exit.first[11:4]       = VEX_EOI_OFFSET[11:4];
            end else begin
                next_exit.first[VEX_RW_BIT] = access.write;          // RL14
                next_exit.first[11:4]       = access.offset[11:4];   // RL15
            end
            // the vector field is undefined elsewhere; zero keeps it stable
            if (next_exit.first[VEX_RW_BIT] &&
                next_exit.first[11:4] == VEX_EOI_OFFSET[11:4])
                next_exit.second[7:0] = access.top_vector;           // RL16
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            exit_valid <= 1'b0;
            exit_info  <= '0;
        end else begin
            exit_valid <= ipi_take || acc_take;                      // RL1 RL12
            if (ipi_take || acc_take)
                exit_info <= next_exit;
        end
    end

    // apb: no wait state; pready and read data both leave flip-flops
    assign apb_write = psel && penable && pready && pwrite;

    always_ff @(posedge clock) begin
        if (sys_rst)
            pready <= 1'b0;
        else
            pready <= psel && !penable;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= 1'b0;
            unique case (paddr)
                VEX_OFF_CTRL:   prdata <= {31'h0, ctrl_en};
                VEX_OFF_STATUS: prdata <= {29'h0, exit_info.code, pending};
                VEX_OFF_CMD_LO: prdata <= intr_cmd_low;
                VEX_OFF_CMD_HI: prdata <= intr_cmd_high;
                VEX_OFF_D1_LO:  prdata <= exit_info.first[31:0];
                VEX_OFF_D1_HI:  prdata <= exit_info.first[63:32];
                VEX_OFF_D2_LO:  prdata <= exit_info.second[31:0];
                VEX_OFF_D2_HI:  prdata <= exit_info.second[63:32];
                default: begin
                    prdata  <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst)
            ctrl_en <= VEX_RST_EN;
        else if (apb_write && paddr == VEX_OFF_CTRL)
            ctrl_en <= pwdata[VEX_CTRL_EN_BIT];
    end

    // guest-written command words, captured into exits
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            intr_cmd_low  <= VEX_RST_CMD;
            intr_cmd_high <= VEX_RST_CMD;
        end else if (apb_write) begin
            if (paddr == VEX_OFF_CMD_LO)
                intr_cmd_low <= pwdata;
            if (paddr == VEX_OFF_CMD_HI)
                intr_cmd_high <= pwdata;
        end
    end

    // sticky pending: a new exit wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (sys_rst)
            pending <= 1'b0;
        else if (ipi_take || acc_take)
            pending <= 1'b1;
        else if (apb_write && paddr == VEX_OFF_STATUS &&
                 pwdata[VEX_STAT_PEND_BIT])
            pending <= 1'b0;
    end

    property p_ipi_high;
        @(posedge clock) disable iff (sys_rst)
        ipi_take |=> exit_valid &&
            exit_info.first[63:32] == $past(intr_cmd_high);
    endproperty
    a_ipi_high: assert property (p_ipi_high)                         // RL2
        else $error("high command word not in first word");

    property p_ipi_low;
        @(posedge clock) disable iff (sys_rst)
        ipi_take |=> exit_info.first[31:0] == $past(intr_cmd_low);
    endproperty
    a_ipi_low: assert property (p_ipi_low)                           // RL3
        else $error("low command word not in first word");

    property p_ipi_reserved;
        @(posedge clock) disable iff (sys_rst)
        exit_valid && exit_info.code == VEX_EXIT_IPI_UNDELIVERED
            |-> exit_info.second[31:8] == 24'h000000;
    endproperty
    a_ipi_reserved: assert property (p_ipi_reserved)                 // RL4
        else $error("reserved second-word bits not zero");

    property p_code0_index;
        @(posedge clock) disable iff (sys_rst)
        ipi_take && (ipi_status.level_trig || ipi_status.dest_unsup)
            |=> exit_info.second[63:32] == VEX_CAUSE_BAD_TYPE &&
                exit_info.second[7:0] == 8'h00;
    endproperty
    a_code0_index: assert property (p_code0_index)                   // RL6
        else $error("bad interrupt type not reported as code 0");

    property p_code_range;
        @(posedge clock) disable iff (sys_rst)
        exit_valid && exit_info.code == VEX_EXIT_IPI_UNDELIVERED
            |-> exit_info.second[63:32] <= VEX_CAUSE_BAD_BACKING;
    endproperty
    a_code_range: assert property (p_code_range)                     // RL11
        else $error("reserved cause code produced");

    property p_not_sched;
        @(posedge clock) disable iff (sys_rst)
        ipi_take && ipi_status.not_sched && !ipi_status.bad_backing &&
        !ipi_status.level_trig && !ipi_status.dest_unsup &&
        !is_bad_target(ipi_status)
            |=> exit_info.second[63:32] == VEX_CAUSE_NOT_SCHED &&
                exit_info.second[7:0] ==
                    $past(dest_index(ipi_status));
    endproperty
    a_not_sched: assert property (p_not_sched)                       // RL7
        else $error("unscheduled target not reported as code 1");

    property p_rw_flag;
        @(posedge clock) disable iff (sys_rst)
        acc_take && !access.eoi_level
            |=> exit_valid && exit_info.first[VEX_RW_BIT] ==
                    $past(access.write) &&
                exit_info.first[63:33] == 31'h0;
    endproperty
    a_rw_flag: assert property (p_rw_flag)                           // RL14
        else $error("read/write flag wrong");

    property p_offset;
        @(posedge clock) disable iff (sys_rst)
        acc_take && !access.eoi_level
            |=> exit_info.first[11:4] == $past(access.offset[11:4]) &&
                exit_info.first[3:0] == 4'h0 &&
                exit_info.first[31:12] == 20'h00000;
    endproperty
    a_offset: assert property (p_offset)                             // RL15
        else $error("register offset field wrong");

    property p_eoi_vector;
        @(posedge clock) disable iff (sys_rst)
        acc_take && access.eoi_level
            |=> exit_info.code == VEX_EXIT_UNACCELERATED_ACCESS &&
                exit_info.second[7:0] == $past(access.top_vector);
    endproperty
    a_eoi_vector: assert property (p_eoi_vector)                     // RL13 RL16
        else $error("eoi vector not reported");

    property p_no_exit_when_idle;
        @(posedge clock) disable iff (sys_rst)
        !ipi_take && !acc_take |=> !exit_valid;
    endproperty
    a_no_exit_when_idle: assert property (p_no_exit_when_idle)       // RL1
        else $error("exit raised without a cause");

    property p_ipi_code;
        @(posedge clock) disable iff (sys_rst)
        ipi_take |=> exit_valid &&
            exit_info.code == VEX_EXIT_IPI_UNDELIVERED;
    endproperty
    a_ipi_code: assert property (p_ipi_code)                         // RL1
        else $error("undelivered ipi exit not raised");

    property p_acc_code;
        @(posedge clock) disable iff (sys_rst)
        acc_take |=> exit_valid &&
            exit_info.code == VEX_EXIT_UNACCELERATED_ACCESS;
    endproperty
    a_acc_code: assert property (p_acc_code)                         // RL12
        else $error("unaccelerated access exit not raised");

    property p_index_reserved;
        @(posedge clock) disable iff (sys_rst)
        exit_valid && exit_info.code == VEX_EXIT_IPI_UNDELIVERED &&
        exit_info.second[63:32] == VEX_CAUSE_BAD_TYPE
            |-> exit_info.second[7:0] == 8'h00;
    endproperty
    a_index_reserved: assert property (p_index_reserved)             // RL5
        else $error("index reported for cause code 0");

    property p_bad_target;
        @(posedge clock) disable iff (sys_rst)
        ipi_take && !ipi_status.level_trig && !ipi_status.dest_unsup &&
        is_bad_target(ipi_status)
            |=> exit_info.second[63:32] == VEX_CAUSE_BAD_TARGET &&
                exit_info.second[7:0] ==
                    $past(dest_index(ipi_status));
    endproperty
    a_bad_target: assert property (p_bad_target)                     // RL8
        else $error("invalid target not reported as code 2");

    property p_bad_backing;
        @(posedge clock) disable iff (sys_rst)
        ipi_take && ipi_status.bad_backing && !ipi_status.level_trig &&
        !ipi_status.dest_unsup && !is_bad_target(ipi_status)
            |=> exit_info.second[63:32] == VEX_CAUSE_BAD_BACKING;
    endproperty
    a_bad_backing: assert property (p_bad_backing)                   // RL9
        else $error("bad backing page not reported as code 3");

    property p_backing_index;
        @(posedge clock) disable iff (sys_rst)
        ipi_take && ipi_status.bad_backing && ipi_status.dest_shorthand &&
        !ipi_status.level_trig && !ipi_status.dest_unsup &&
        !is_bad_target(ipi_status)
            |=> exit_info.second[7:0] == $past(ipi_status.phys_index);
    endproperty
    a_backing_index: assert property (p_backing_index)               // RL10
        else $error("shorthand code 3 index not physical");

    property p_level_eoi;
        @(posedge clock) disable iff (sys_rst)
        ctrl_en && access.eoi_level && !ipi_take
            |=> exit_valid && exit_info.first[VEX_RW_BIT] &&
                exit_info.first[11:4] == VEX_EOI_OFFSET[11:4];
    endproperty
    a_level_eoi: assert property (p_level_eoi)                       // RL13
        else $error("level eoi did not raise an access exit");

    property p_vector_zero;
        @(posedge clock) disable iff (sys_rst)
        acc_take && !access.eoi_level &&
        !(access.write && access.offset[11:4] == VEX_EOI_OFFSET[11:4])
            |=> exit_info.second == 64'h0;
    endproperty
    a_vector_zero: assert property (p_vector_zero)    // RL16 RL17
        else $error("vector field set outside an eoi write");

    property p_acc_reserved;
        @(posedge clock) disable iff (sys_rst)
        exit_valid && exit_info.code == VEX_EXIT_UNACCELERATED_ACCESS
            |-> exit_info.first[63:33] == 31'h0 &&
                exit_info.first[31:12] == 20'h00000 &&
                exit_info.first[3:0] == 4'h0 &&
                exit_info.second[63:8] == 56'h0;
    endproperty
    a_acc_reserved: assert property (p_acc_reserved)                 // RL17
        else $error("reserved access exit bits not zero");

endmodule : vex_encoder

// ==== tb/test_vex_encoder.sv ====
module test_vex_encoder
    import vex_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] CMD_LO = 32'hc0de_0a01;
    localparam logic [31:0] CMD_HI = 32'h0300_00f1;

    typedef struct packed {
        vex_ipi_status_t ipi;
        vex_access_t     acc;
        logic            ev;
        vex_exit_t       exp;
    } vex_row_t;

    logic            clock      = 1'b0;
    logic            sys_rst    = 1'b1;
    logic            psel       = 1'b0;
    logic            penable    = 1'b0;
    logic            pwrite     = 1'b0;
    logic [7:0]      paddr      = 8'h00;
    logic [31:0]     pwdata     = 32'h0;
    logic            pready;
    logic [31:0]     prdata;
    logic            pslverr;
    vex_ipi_status_t ipi_status = '0;
    vex_access_t     access     = '0;
    logic            exit_valid;
    vex_exit_t       exit_info;
    int              n_mismatch = 0;
    int              samples_checked = 0;
    vex_row_t        rows[$];

    vex_encoder u_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ipi_status(ipi_status), .access(access), .exit_valid(exit_valid),
        .exit_info(exit_info));

    initial begin
        forever #10 clock = ~clock;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [129:0] seen,
                       input logic [129:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one transfer; waits an edge first so back-to-back calls never
    // assign psel twice in one time step
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 8);
        if (pready !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end else begin
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic rd_chk(input string what, input logic [7:0] addr,
                          input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, addr, 32'h0, rd, err);
        chk(what, 130'({err, rd}), 130'({1'b0, exp}));
    endtask : rd_chk

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, addr, wd, rd, err);
    endtask : wr

    // exit appears exactly one edge after the event edge
    task automatic fire(input vex_row_t r, input string what);
        @(posedge clock);
        ipi_status <= r.ipi;
        access     <= r.acc;
        @(posedge clock);
        ipi_status <= '0;
        access     <= '0;
        @(posedge clock);
        chk({what, " valid"}, 130'(exit_valid), 130'(r.ev));
        if (r.ev) begin
            chk(what, exit_info, r.exp);
        end
        @(posedge clock);
        chk({what, " pulse"}, 130'(exit_valid), 130'h0);
    endtask : fire

    function automatic vex_ipi_status_t mk(input logic [4:0] f,
        input logic [7:0] cl, input logic [9:0] pt, input logic [1:0] bn,
        input logic [7:0] pi, input logic [7:0] li);
        mk = {1'b1, f, cl, pt, bn, pi, li};
    endfunction : mk

    function automatic vex_access_t mka(input logic [1:0] vw,
        input logic [11:0] off, input logic el, input logic [7:0] tv);
        mka = {vw, off, el, tv};
    endfunction : mka

    function automatic vex_exit_t ie(input logic [31:0] c,
                                     input logic [7:0] idx);
        ie = '{VEX_EXIT_IPI_UNDELIVERED, {CMD_HI, CMD_LO}, {c, 24'h0, idx}};
    endfunction : ie

    function automatic vex_exit_t ae(input logic [63:0] f,
                                     input logic [63:0] s);
        ae = '{VEX_EXIT_UNACCELERATED_ACCESS, f, s};
    endfunction : ae

    task automatic add(input vex_ipi_status_t i, input vex_access_t a,
                       input logic e, input vex_exit_t x);
        rows.push_back('{i, a, e, x});
    endtask : add

    initial begin
        logic [31:0] rd;
        logic        err;
        add(mk(5'h00, 8'h01, 10'h001, 2'b01, 8'h05, 8'h21), '0, 1'b1,
            ie(VEX_CAUSE_NOT_SCHED, 8'h05));
        add(mk(5'h04, 8'h01, 10'h001, 2'b01, 8'h05, 8'h21), '0, 1'b1,
            ie(VEX_CAUSE_NOT_SCHED, 8'h21));
        add(mk(5'h10, 8'h01, 10'h001, 2'b01, 8'h05, 8'h21), '0, 1'b1,
            ie(VEX_CAUSE_BAD_TYPE, 8'h00));
        add(mk(5'h08, 8'h01, 10'h001, 2'b00, 8'h05, 8'h21), '0, 1'b1,
            ie(VEX_CAUSE_BAD_TYPE, 8'h00));
        add(mk(5'h04, 8'h41, 10'h001, 2'b01, 8'h05, 8'h21), '0, 1'b1,
            ie(VEX_CAUSE_BAD_TARGET, 8'h21));
        add(mk(5'h04, 8'h40, 10'h3ff, 2'b01, 8'h05, 8'h21), '0, 1'b1,
            ie(VEX_CAUSE_NOT_SCHED, 8'h21));
        add(mk(5'h00, 8'hff, 10'h201, 2'b00, 8'h05, 8'h21), '0, 1'b1,
            ie(VEX_CAUSE_BAD_TARGET, 8'h05));
        add(mk(5'h00, 8'hff, 10'h200, 2'b01, 8'h05, 8'h21), '0, 1'b1,
            ie(VEX_CAUSE_NOT_SCHED, 8'h05));
        add(mk(5'h01, 8'h01, 10'h001, 2'b00, 8'h05, 8'h21), '0, 1'b1,
            ie(VEX_CAUSE_BAD_TARGET, 8'h05));
        add(mk(5'h06, 8'h01, 10'h001, 2'b10, 8'h05, 8'h21), '0, 1'b1,
            ie(VEX_CAUSE_BAD_BACKING, 8'h05));
        add(mk(5'h04, 8'h01, 10'h001, 2'b11, 8'h05, 8'h21), '0, 1'b1,
            ie(VEX_CAUSE_BAD_BACKING, 8'h21));
        add(mk(5'h00, 8'h01, 10'h001, 2'b00, 8'h05, 8'h21), '0, 1'b0,
            '0);
        add('0, mka(2'b10, 12'h3f7, 1'b0, 8'h99), 1'b1,
            ae(64'h3f0, 64'h0));
        add('0, mka(2'b11, 12'h0b0, 1'b0, 8'h31), 1'b1,
            ae(64'h1_0000_00b0, 64'h31));
        add('0, mka(2'b11, 12'h380, 1'b0, 8'h55), 1'b1,
            ae(64'h1_0000_0380, 64'h0));
        add('0, mka(2'b00, 12'h000, 1'b1, 8'h62), 1'b1,
            ae(64'h1_0000_00b0, 64'h62));
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        chk("valid after reset", 130'(exit_valid), 130'h0);
        chk("exit after reset", exit_info, 130'h0);
        rd_chk("ctrl reset", VEX_OFF_CTRL, 32'h1);
        rd_chk("status reset", VEX_OFF_STATUS, 32'h0);
        apb(1'b0, 8'h20, 32'h0, rd, err);
        chk("unmapped", 130'({err, rd}), 130'({1'b1, 32'h0}));
        chk("unmapped err", 130'(pslverr), 130'h1);
        wr(VEX_OFF_CMD_LO, CMD_LO);
        wr(VEX_OFF_CMD_HI, CMD_HI);
        rd_chk("cmd low", VEX_OFF_CMD_LO, CMD_LO);
        rd_chk("cmd high", VEX_OFF_CMD_HI, CMD_HI);
        foreach (rows[i]) begin
            fire(rows[i], $sformatf("row %0d", i));
        end
        // an access in the same cycle as an ipi exit is dropped
        fire('{rows[0].ipi, rows[12].acc, 1'b1, rows[0].exp}, "both");
        rd_chk("first lo", VEX_OFF_D1_LO, CMD_LO);
        rd_chk("first hi", VEX_OFF_D1_HI, CMD_HI);
        rd_chk("second lo", VEX_OFF_D2_LO, 32'h05);
        rd_chk("second hi", VEX_OFF_D2_HI, VEX_CAUSE_NOT_SCHED);
        rd_chk("status pending", VEX_OFF_STATUS, 32'h3);
        wr(VEX_OFF_STATUS, 32'h1);
        rd_chk("status cleared", VEX_OFF_STATUS, 32'h2);
        wr(VEX_OFF_CTRL, 32'h0);
        fire('{rows[0].ipi, '0, 1'b0, '0}, "disabled");
        wr(VEX_OFF_CTRL, 32'h1);
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        chk("valid after rerun", 130'(exit_valid), 130'h0);
        chk("exit after rerun", exit_info, 130'h0);
        rd_chk("cmd low rerun", VEX_OFF_CMD_LO, 32'h0);
        finish_test();
    end
endmodule : test_vex_encoder
